// ==== rsc_ctrl.sv ====
// reset source controller: sequencer, source flags, reset pin drive and AXI4-Lite registers
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rsc_regs.svh"
module rsc_ctrl #(
  parameter int STARTUP_CYCLES = `RSC_STARTUP_CYCLES,
  parameter int OSC_LIMIT_CYCLES = `RSC_OSC_LIMIT_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vcc_ok_in,
  input wire logic main_osc_in,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_out,
  input wire logic wdt_enable_in,
  input wire logic wdt_timeout_in,
  output logic core_reset_out,
  output logic reset_vector_out,
  output logic osc_enable_out,
  output logic ring_osc_sel_out,
  output logic clk_div_one_out,
  output logic bank_map_out
);
  localparam logic [16:0] START_LOAD = 17'(STARTUP_CYCLES - 1);
  localparam logic [16:0] SHORT_LOAD = 17'(`RSC_SHORT_CYCLES - 1);
  localparam logic [16:0] EXIT_LOAD = 17'(`RSC_EXIT_CYCLES - 1);
  localparam logic [2:0] EXT_MIN = 3'(`RSC_EXT_MIN_CYCLES);
  localparam logic [15:0] OSC_LIMIT = 16'(OSC_LIMIT_CYCLES);

  rsc_pkg::rsc_state_t state_q;
  rsc_pkg::rsc_state_t state_d;
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic [2:0] sync_s;
  logic vcc_s;
  logic osc_s;
  logic pin_s;
  logic osc_prev_q;
  logic [15:0] gap_q;
  logic [2:0] ext_cnt_q;
  logic por_q;
  logic wdrf_q;
  logic det_en_q;
  logic off_q;
  logic stop_q;
  logic bank_sel_q;
  logic bank_map_q;
  logic drive_q;
  logic [1:0] ta_q;
  logic core_rst_q;
  logic vec_q;
  logic sb_q;
  logic ring_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // vcc, main oscillator and reset pin all arrive from outside the clock domain
  rsc_sync #(.WIDTH(3)) u_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .async_in({vcc_ok_in, main_osc_in, rst_pin_in}),
    .sync_out(sync_s)
  );
  assign vcc_s = sync_s[2];
  assign osc_s = sync_s[1];
  assign pin_s = sync_s[0];

  // bus write path: address and data taken in either order, then one response
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_hold_q | aw_take;
  wire w_have = w_hold_q | w_take;
  wire do_write = aw_have & w_have;
  wire [7:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [7:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata[7:0];
  wire wr_lane0 = w_hold_q ? wstrb0_q : s_axi_wstrb[0];
  wire wr_hit_wdog = wr_addr == `RSC_ADDR_WDOG;
  wire wr_hit_pwr = wr_addr == `RSC_ADDR_PWR;
  wire wr_hit_flash = wr_addr == `RSC_ADDR_FLASH;
  wire wr_hit_ta = wr_addr == `RSC_ADDR_TA;
  wire wr_hit_st = wr_addr == `RSC_ADDR_STATUS;
  wire wr_mapped = wr_hit_wdog | wr_hit_pwr | wr_hit_flash | wr_hit_ta | wr_hit_st;
  wire wr_en = do_write & wr_lane0;
  wire wr_wdog = wr_en & wr_hit_wdog;
  wire wr_pwr = wr_en & wr_hit_pwr;
  wire wr_flash = wr_en & wr_hit_flash;
  wire wr_ta = wr_en & wr_hit_ta;
  wire ta_open = ta_q == 2'h2;
  wire [3:0] cmd = wr_data[3:0];
  // command field only acts inside the timed-access window
  wire fl_sysrst = wr_flash & ta_open & (cmd == `RSC_CMD_SYSRST);
  wire fl_cbank = wr_flash & ta_open & (cmd == `RSC_CMD_CBANK);

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // reset source detection
  wire osc_edge = osc_s ^ osc_prev_q;
  wire gap_sat = gap_q >= OSC_LIMIT;
  wire pwr_bad = ~vcc_s;
  wire osc_fail = det_en_q & ~stop_q & gap_sat;
  wire ext_hit = ext_cnt_q == EXT_MIN;
  wire stop_hit = stop_q & pin_s;
  wire wd_hit = wdt_enable_in & wdt_timeout_in;
  wire fl_hit = fl_sysrst | fl_cbank;
  wire in_run = state_q == rsc_pkg::RSC_RUN;
  wire leave = ~in_run & (state_d == rsc_pkg::RSC_RUN);
  wire enter_pwr = pwr_bad & (state_q != rsc_pkg::RSC_POWER);
  wire enter_osc = (state_d == rsc_pkg::RSC_OSC) & (state_q != rsc_pkg::RSC_OSC);
  wire enter_wd = in_run & (state_d == rsc_pkg::RSC_SHORT) & wd_hit;
  wire enter_fl = in_run & (state_d == rsc_pkg::RSC_SHORT) & ~wd_hit;
  wire enter_ext = in_run & ((state_d == rsc_pkg::RSC_EXT) | (state_d == rsc_pkg::RSC_START));
  wire cnt_zero = cnt_q == 17'h00000;

  // each source lands in a reset state (POWER, START, SHORT, EXT or OSC), watchdog and flash command both in SHORT; the oscillator stops only through stop_q
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 17'h00001;
    if (pwr_bad) begin
      state_d = rsc_pkg::RSC_POWER;
    end else begin
      case (state_q)
        rsc_pkg::RSC_RUN: begin
          if (osc_fail) begin
            state_d = rsc_pkg::RSC_OSC;
          end else if (stop_hit) begin
            state_d = rsc_pkg::RSC_START;
            cnt_d = START_LOAD;
          end else if (ext_hit) begin
            state_d = rsc_pkg::RSC_EXT;
          end else if (wd_hit | fl_hit) begin
            state_d = rsc_pkg::RSC_SHORT;
            cnt_d = SHORT_LOAD;
          end
        end
        rsc_pkg::RSC_POWER: begin
          state_d = rsc_pkg::RSC_START;
          cnt_d = START_LOAD;
        end
        rsc_pkg::RSC_START: begin
          if (cnt_zero) begin
            state_d = rsc_pkg::RSC_RUN;
          end
        end
        rsc_pkg::RSC_SHORT: begin
          if (osc_fail) begin
            state_d = rsc_pkg::RSC_OSC;
          end else if (cnt_zero) begin
            state_d = rsc_pkg::RSC_RUN;
          end
        end
        rsc_pkg::RSC_EXT: begin
          if (!pin_s) begin
            state_d = rsc_pkg::RSC_EXIT;
            cnt_d = EXIT_LOAD;
          end
        end
        rsc_pkg::RSC_EXIT: begin
          if (cnt_zero) begin
            state_d = rsc_pkg::RSC_RUN;
          end
        end
        rsc_pkg::RSC_OSC: begin
          if (!gap_sat) begin
            state_d = rsc_pkg::RSC_EXIT;
            cnt_d = EXIT_LOAD;
          end
        end
        default: begin
          state_d = rsc_pkg::RSC_POWER;
        end
      endcase
    end
  end

  // flag next values: hardware set wins over a software write in the same cycle
  wire por_d = enter_pwr ? 1'b1 : (wr_wdog ? wr_data[`RSC_WDOG_POR_BIT] : por_q);
  wire wdrf_d = enter_wd ? 1'b1 : (wr_wdog ? wr_data[`RSC_WDOG_WDRF_BIT] : wdrf_q);
  wire off_set = enter_osc;
  wire off_d = off_set ? 1'b1 : ((wr_pwr ? wr_data[`RSC_PWR_OFF_BIT] : off_q) & ~enter_pwr);
  wire det_en_d = enter_pwr ? 1'b0 : (wr_pwr ? wr_data[`RSC_PWR_DET_BIT] : det_en_q);
  wire stop_d = ~in_run | stop_hit ? 1'b0 : (wr_pwr ? wr_data[`RSC_PWR_STOP_BIT] : stop_q);
  wire bank_d = fl_cbank ? ~bank_sel_q : (wr_flash ? wr_data[`RSC_FLASH_BANK_BIT] : bank_sel_q);
  // own pin drive is masked from the pin filter; the synchroniser lag after release is
  // shorter than the four-cycle minimum, so our own pulse never reads back as external
  wire drive_d = (enter_pwr | enter_osc | enter_wd | enter_fl) ? 1'b1 :
                 ((enter_ext | leave) ? 1'b0 : drive_q);
  wire [2:0] ext_cnt_d = (~pin_s | drive_q) ? 3'h0 : (ext_hit ? ext_cnt_q : ext_cnt_q + 3'h1);
  wire [15:0] gap_d = osc_edge ? 16'h0000 : (gap_sat ? gap_q : gap_q + 16'h0001);
  wire [1:0] ta_d = ~wr_en ? ta_q :
                    (wr_ta & (wr_data == `RSC_TA_KEY1)) ? 2'h1 :
                    (wr_ta & (wr_data == `RSC_TA_KEY2) & (ta_q == 2'h1)) ? 2'h2 : 2'h0;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= rsc_pkg::RSC_POWER;
      cnt_q <= 17'h00000;
      core_rst_q <= 1'b1;
      vec_q <= 1'b0;
      sb_q <= 1'b0;
      ring_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      core_rst_q <= state_d != rsc_pkg::RSC_RUN;
      vec_q <= leave;
      sb_q <= enter_pwr | enter_wd | enter_ext;
      ring_q <= state_d == rsc_pkg::RSC_OSC;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      por_q <= `RSC_RST_POR;
      wdrf_q <= `RSC_RST_WDRF;
      off_q <= `RSC_RST_OFF;
      det_en_q <= `RSC_RST_DET;
      stop_q <= 1'b0;
      bank_sel_q <= `RSC_RST_BANK;
      bank_map_q <= `RSC_RST_BANK;
      drive_q <= 1'b1;
      ext_cnt_q <= 3'h0;
      gap_q <= 16'h0000;
      osc_prev_q <= 1'b0;
      ta_q <= 2'h0;
    end else begin
      por_q <= por_d;
      wdrf_q <= wdrf_d;
      off_q <= off_d;
      det_en_q <= det_en_d;
      stop_q <= stop_d;
      bank_sel_q <= bank_d;
      bank_map_q <= leave ? bank_sel_q : bank_map_q;
      drive_q <= drive_d;
      ext_cnt_q <= ext_cnt_d;
      gap_q <= gap_d;
      osc_prev_q <= osc_s;
      ta_q <= ta_d;
    end
  end

  // write channel and response
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RSC_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end else begin
        aw_hold_q <= aw_have;
        w_hold_q <= w_have;
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // read decode; the command field always reads as zero
  wire [31:0] rd_wdog = 32'(por_q) << `RSC_WDOG_POR_BIT | 32'(wdrf_q) << `RSC_WDOG_WDRF_BIT;
  wire [31:0] rd_pwr = 32'(off_q) << `RSC_PWR_OFF_BIT | 32'(det_en_q) << `RSC_PWR_DET_BIT |
                       32'(stop_q) << `RSC_PWR_STOP_BIT;
  wire [31:0] rd_flash = 32'(bank_sel_q) << `RSC_FLASH_BANK_BIT;
  wire [31:0] rd_ta = {30'h00000000, ta_q};
  wire [31:0] rd_st = {25'h0000000, state_q} | 32'(drive_q) << `RSC_ST_DRIVE_BIT |
                      32'(bank_map_q) << `RSC_ST_BANKMAP_BIT | 32'(pin_s) << `RSC_ST_PIN_BIT;
  wire rd_mapped = (s_axi_araddr == `RSC_ADDR_WDOG) | (s_axi_araddr == `RSC_ADDR_PWR) |
                   (s_axi_araddr == `RSC_ADDR_FLASH) | (s_axi_araddr == `RSC_ADDR_TA) |
                   (s_axi_araddr == `RSC_ADDR_STATUS);
  wire [31:0] rd_mux = (s_axi_araddr == `RSC_ADDR_WDOG) ? rd_wdog :
                       (s_axi_araddr == `RSC_ADDR_PWR) ? rd_pwr :
                       (s_axi_araddr == `RSC_ADDR_FLASH) ? rd_flash :
                       (s_axi_araddr == `RSC_ADDR_TA) ? rd_ta :
                       (s_axi_araddr == `RSC_ADDR_STATUS) ? rd_st : 32'h00000000;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_mapped ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rst_pin_out = 1'b1;
  assign rst_pin_oe_out = drive_q;
  assign core_reset_out = core_rst_q;
  assign reset_vector_out = vec_q;
  assign osc_enable_out = ~stop_q;
  assign ring_osc_sel_out = ring_q;
  assign clk_div_one_out = sb_q;
  assign bank_map_out = bank_map_q;
endmodule // rsc_ctrl

// ==== rsc_regs.svh ====
// register map, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
`define RSC_ADDR_WDOG 8'h00
`define RSC_ADDR_PWR 8'h04
`define RSC_ADDR_FLASH 8'h08
`define RSC_ADDR_TA 8'h0C
`define RSC_ADDR_STATUS 8'h10
`define RSC_WDOG_POR_BIT 6
`define RSC_WDOG_WDRF_BIT 3
`define RSC_PWR_OFF_BIT 5
`define RSC_PWR_DET_BIT 4
`define RSC_PWR_STOP_BIT 1
`define RSC_FLASH_BANK_BIT 4
`define RSC_ST_DRIVE_BIT 7
`define RSC_ST_BANKMAP_BIT 8
`define RSC_ST_PIN_BIT 9
`define RSC_CMD_SYSRST 4'h1
`define RSC_CMD_CBANK 4'h2
`define RSC_TA_KEY1 8'hAA
`define RSC_TA_KEY2 8'h55
`define RSC_RST_POR 1'b1
`define RSC_RST_WDRF 1'b0
`define RSC_RST_DET 1'b0
`define RSC_RST_OFF 1'b0
`define RSC_RST_BANK 1'b0
`define RSC_CLK_MHZ 250
`define RSC_OSC_MIN_KHZ 20
`define RSC_STARTUP_CYCLES 65536
`define RSC_SHORT_CYCLES 13
`define RSC_EXT_MIN_CYCLES 4
`define RSC_EXIT_CYCLES 2
`define RSC_OSC_LIMIT_CYCLES (`RSC_CLK_MHZ * 1000 / `RSC_OSC_MIN_KHZ)
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`endif

// ==== rsc_pkg.sv ====
// types shared by the reset source controller
package rsc_pkg;
  typedef enum logic [6:0] {
    RSC_RUN = 7'h01,
    RSC_POWER = 7'h02,
    RSC_START = 7'h04,
    RSC_SHORT = 7'h08,
    RSC_EXT = 7'h10,
    RSC_EXIT = 7'h20,
    RSC_OSC = 7'h40
  } rsc_state_t;
endpackage

// ==== rsc_sync.sv ====
// two flip-flop synchroniser for independent level inputs
`timescale 1ns/1ns
module rsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // rsc_sync

// ==== rsc_ctrl_props.sv ====
// port assertions for the reset source controller
`timescale 1ns/1ns
module rsc_ctrl_props (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic vcc_ok_in,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_out,
  input wire logic wdt_enable_in,
  input wire logic wdt_timeout_in,
  input wire logic core_reset_out,
  input wire logic reset_vector_out,
  input wire logic ring_osc_sel_out,
  input wire logic clk_div_one_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence wdt_hit;
    wdt_enable_in && wdt_timeout_in && !core_reset_out;
  endsequence
  sequence held8;
    core_reset_out [*8];
  endsequence
  wdt_reset_a: assert property (wdt_hit |-> ##2 held8)
    else $error("watchdog reset ended early");
  div_one_a: assert property (wdt_hit |-> ##[1:20] clk_div_one_out)
    else $error("no divide-by-one switchback");
  vec_pulse_a: assert property ($rose(reset_vector_out) |=> !reset_vector_out && !core_reset_out)
    else $error("reset vector pulse wrong");
  pin_drive_a: assert property (rst_pin_oe_out |-> core_reset_out && rst_pin_out)
    else $error("pin driven outside internal reset");
  ring_sel_a: assert property (ring_osc_sel_out |-> core_reset_out && rst_pin_oe_out)
    else $error("ring clock without held reset");
  vcc_low_a: assert property (!vcc_ok_in |-> ##[1:4] (core_reset_out && rst_pin_oe_out))
    else $error("low supply not holding reset");
  // a pin held eight cycles by the board must be seen; our own drive is not a request
  ext_pin_a: assert property ((rst_pin_in && !rst_pin_oe_out) [*8] |-> ##2 core_reset_out)
    else $error("pin reset not taken");
  ext_exit_a: assert property ($fell(rst_pin_in) && !$past(rst_pin_oe_out) |-> ##[1:8] !core_reset_out)
    else $error("pin reset exit too slow");
  bus_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // rsc_ctrl_props

bind rsc_ctrl rsc_ctrl_props i_rsc_ctrl_props (.*);

// ==== rsc_ext_rst.sv ====
// model of the board circuit that drives the reset pin high
`timescale 1ns/1ns
module rsc_ext_rst (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [7:0] len_in,
  output logic pin_drive_out
);
  logic [7:0] cnt_q = 8'h00;
  // whole cycles only, never shorter than asked
  always_ff @(posedge clk_in) begin
    if (req_in) begin
      cnt_q <= len_in;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign pin_drive_out = (cnt_q != 8'h00);
endmodule // rsc_ext_rst

// ==== tb_top.sv ====
// self-checking bench for the reset source controller
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] A_WDOG = 8'h00;
  localparam logic [7:0] A_PWR = 8'h04;
  localparam logic [7:0] A_FLASH = 8'h08;
  localparam logic [7:0] A_KEY = 8'h0C;
  logic sys_clk_in = 1'b0;
  logic resetn_in, vcc_ok_in, main_osc_in, rst_pin_in, wdt_enable_in, wdt_timeout_in;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ext_len;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rst_pin_out, rst_pin_oe_out;
  logic core_reset_out, reset_vector_out, osc_enable_out, ring_osc_sel_out, clk_div_one_out;
  logic bank_map_out, osc_run, ext_req, pin_drv, bk;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'h1510;
  int hi, oe;

  always #2 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (osc_run) main_osc_in <= ~main_osc_in;
  // a released pin is pulled low on the board
  assign rst_pin_in = pin_drv | (rst_pin_oe_out & rst_pin_out);

  rsc_ctrl #(.STARTUP_CYCLES(16), .OSC_LIMIT_CYCLES(40)) i_rsc_ctrl (.*);
  rsc_ext_rst i_rsc_ext_rst (.clk_in(sys_clk_in), .req_in(ext_req), .len_in(ext_len),
    .pin_drive_out(pin_drv));

  function automatic logic [31:0] fbit(input int p);
    return 32'h1 << p;
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h", $time, m, g);
    end
  endtask

  task automatic chk_cyc(input int n, input int lo, input int up, input string m);
    n_checks++;
    if (n < lo || n > up) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %0d", $time, m, n);
    end
  endtask

  task automatic hang(input string m);
    chk(32'h0, 32'h1, m);
    stop_test();
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    s_axi_bready <= 1'b0;
    if (n >= 64) hang("write hang");
    chk({30'h0, s_axi_bresp}, 32'h0, "write response");
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 64) hang("read hang");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a, d, r);
    chk(d, e, "register value");
  endtask

  // waits a bounded time for reset, then counts held and pin-driven cycles
  task automatic rst_len(output int h, output int o);
    int n;
    h = 0;
    o = 0;
    n = 0;
    while (!core_reset_out && n < 80) begin
      @(posedge sys_clk_in);
      n++;
    end
    while (core_reset_out) begin
      h++;
      if (rst_pin_oe_out) o++;
      if (h > 70000) hang("reset hang");
      @(posedge sys_clk_in);
    end
  endtask

  task automatic wdt_pulse;
    @(posedge sys_clk_in);
    wdt_timeout_in <= 1'b1;
    @(posedge sys_clk_in);
    wdt_timeout_in <= 1'b0;
  endtask

  initial begin
    #400000;
    hang("run limit");
  end

  initial begin
    resetn_in = 1'b0;
    vcc_ok_in = 1'b1;
    main_osc_in = 1'b0;
    osc_run = 1'b1;
    {wdt_enable_in, wdt_timeout_in, ext_req, ext_len} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rst_len(hi, oe);
    chk_cyc(hi, 16, 24, "start count");
    rd_chk(A_WDOG, fbit(6));
    bus_wr(A_WDOG, 32'h0);
    rd_chk(A_WDOG, 32'h0);
    bus_rd(8'h14, d, r);
    chk({30'h0, r}, 32'h2, "unmapped response");
    chk(d, 32'h0, "unmapped data");
    $display("test power-on finished");
    wdt_pulse();
    rst_len(hi, oe);
    chk_cyc(hi, 0, 0, "watchdog off");
    wdt_enable_in <= 1'b1;
    repeat ({$random(seed)} % 8) @(posedge sys_clk_in);
    wdt_pulse();
    rst_len(hi, oe);
    chk_cyc(hi, 13, 13, "watchdog length");
    chk_cyc(oe, 13, 13, "watchdog pin drive");
    rd_chk(A_WDOG, fbit(3));
    $display("test watchdog finished");
    bus_wr(A_FLASH, 32'h1);
    rst_len(hi, oe);
    chk_cyc(hi, 0, 0, "command without key");
    for (int i = 1; i < 3; i++) begin
      bk = 1'($random(seed));
      bus_wr(A_FLASH, {27'h0, bk, 4'h0});
      bus_wr(A_KEY, 32'hAA);
      bus_wr(A_KEY, 32'h55);
      bus_wr(A_FLASH, {27'h0, bk, 4'(i)});
      if (i == 2) bk = ~bk;
      rst_len(hi, oe);
      chk_cyc(hi, 13, 13, "flash reset length");
      chk_cyc(oe, 13, 13, "flash pin drive");
      chk({31'h0, bank_map_out}, {31'h0, bk}, "bank order");
      rd_chk(A_WDOG, fbit(3));
    end
    bus_wr(A_WDOG, 32'h0);
    $display("test flash finished");
    repeat (3) begin
      ext_len <= 8'(12 + {$random(seed)} % 40);
      ext_req <= 1'b1;
      @(posedge sys_clk_in);
      ext_req <= 1'b0;
      rst_len(hi, oe);
      chk_cyc(hi, int'(ext_len) - 8, int'(ext_len) + 2, "pin reset span");
      chk_cyc(oe, 0, 0, "pin not driven");
    end
    rd_chk(A_WDOG, 32'h0);
    rd_chk(A_PWR, 32'h0);
    $display("test pin finished");
    bus_wr(A_PWR, fbit(4));
    osc_run <= 1'b0;
    fork
      begin
        repeat (60) @(posedge sys_clk_in);
        chk({31'h0, ring_osc_sel_out}, 32'h1, "ring clock");
        repeat (20) @(posedge sys_clk_in);
        osc_run <= 1'b1;
      end
      rst_len(hi, oe);
    join
    chk_cyc(hi, 30, 50, "held until clock returns");
    chk_cyc(oe, hi, hi, "osc pin drive");
    rd_chk(A_PWR, fbit(5) | fbit(4));
    $display("test oscillator finished");
    bus_wr(A_PWR, 32'h32);
    osc_run <= 1'b0;
    rst_len(hi, oe);
    chk_cyc(hi, 0, 0, "stopped clock no reset");
    ext_len <= 8'h0C;
    ext_req <= 1'b1;
    osc_run <= 1'b1;
    @(posedge sys_clk_in);
    ext_req <= 1'b0;
    rst_len(hi, oe);
    chk_cyc(hi, 16, 24, "pin wake from stop");
    chk({31'h0, osc_enable_out}, 32'h1, "clock restarted");
    bus_wr(A_PWR, 32'h32);
    osc_run <= 1'b0;
    vcc_ok_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    chk({31'h0, core_reset_out & rst_pin_oe_out}, 32'h1, "low supply");
    vcc_ok_in <= 1'b1;
    osc_run <= 1'b1;
    rst_len(hi, oe);
    chk_cyc(hi, 16, 24, "full start after dip");
    chk({31'h0, osc_enable_out}, 32'h1, "clock back on");
    rd_chk(A_WDOG, fbit(6));
    rd_chk(A_PWR, 32'h0);
    $display("test power fail finished");
    stop_test();
  end
endmodule // tb_top
